// file: inc/fault_resp_pkg.sv
// Purpose: Shared constants and types for the motor fault response controller.
// Assumes: 32-bit AXI4-Lite register bus, 100 MHz aclk.
// Notes: Diagnostic bit positions are shared by registers and logic; the raw input vector uses its own order.
package fault_resp_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] MASK_OFS = 8'h04;
  localparam logic [7:0] DIAG_OFS = 8'h08;
  localparam logic [7:0] STATE_OFS = 8'h0C;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h10;
  localparam logic [7:0] IRQ_CLR_OFS = 8'h14;
  localparam logic [7:0] IRQ_EN_OFS = 8'h18;

  // Control register fields
  localparam int CTRL_STOP_ON_FAULT_BIT = 0;
  localparam int CTRL_AUTO_RESTART_BIT = 1;
  localparam int CTRL_RUN_BIT = 2;
  localparam int CTRL_INHIBIT_BIT = 3;
  localparam int CTRL_DEMAND_LSB = 8;
  localparam int DEMAND_W = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_WMASK = 32'h0000_FF0F;

  // Diagnostic bit positions (also mask, irq status, clear and enable layout)
  localparam int DIAG_W = 9;
  localparam int DG_SUPPLY_UV = 0;
  localparam int DG_GATE_SUPPLY_UV = 1;
  localparam int DG_POR = 2;
  localparam int DG_SHORT = 3;
  localparam int DG_BOOT_UV = 4;
  localparam int DG_OVER_TEMP = 5;
  localparam int DG_LOSS_SYNC = 6;
  localparam int DG_LOGIC_UV = 7;
  localparam int DG_WD_FAULT = 8;
  localparam logic [DIAG_W-1:0] MASK_RESET = 9'h000;
  localparam logic [DIAG_W-1:0] UNMASKABLE = 9'h006;

  // Transistor and phase counts
  localparam int FET_N = 6;
  localparam int PHASE_N = 3;

  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int OT_HOLD_MS = 10;
  localparam int WD_ARM_MS = 100;
  localparam int NS_PER_MS = 1000000;
  localparam int CNT_W = 24;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    MR_IDLE = 4'h1,
    MR_HOLD = 4'h2,
    MR_WAIT = 4'h4,
    MR_ARM = 4'h8
  } mcu_rst_e;

endpackage : fault_resp_pkg

// file: verilog/motor_fault_response_controller.sv
// Purpose: Gate drive fault response, fault latching and release, MCU reset sequencing.
// Assumes: Fault detectors and pwm_on come from outside the aclk domain.
// Notes: Registers over AXI4-Lite; one level interrupt output.
//
// The implementer's own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

module motor_fault_response_controller
  import fault_resp_pkg::*;
#(
  parameter int OT_HOLD_CYC = OT_HOLD_MS * (NS_PER_MS / CLK_PERIOD_NS),
  parameter int WD_ARM_CYC = WD_ARM_MS * (NS_PER_MS / CLK_PERIOD_NS)
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic motor_supply_uv,
  input wire logic motor_supply_por,
  input wire logic gate_drive_supply_uv,
  input wire logic logic_regulator_uv,
  input wire logic watchdog_fault,
  input wire logic watchdog_in,
  input wire logic over_temp,
  input wire logic loss_of_sync,
  input wire logic [FET_N-1:0] short_fault,
  input wire logic [FET_N-1:0] bootstrap_uv,
  input wire logic [PHASE_N-1:0] pwm_on,
  output logic [FET_N-1:0] gate_enable,
  output logic mcu_reset_out_n,
  output logic start_request,
  output logic irq
);

  localparam int RAW_W = 8 + 2 * FET_N + PHASE_N;

  typedef struct packed {
    logic [RAW_W-1:0] sync1;
    logic [RAW_W-1:0] sync2;
    logic [RAW_W-1:0] prev;
    logic [31:0] ctrl;
    logic [DIAG_W-1:0] mask;
    logic [DIAG_W-1:0] diag;
    logic [DIAG_W-1:0] ev_prev;
    logic [DIAG_W-1:0] irq_stat;
    logic [DIAG_W-1:0] irq_en;
    logic demand_zero_seen;
    logic run_low_seen;
    logic read_release;
    logic uv_lat;
    logic bridge_lat;
    logic los_lat;
    logic [FET_N-1:0] fet_lat;
    mcu_rst_e mr;
    logic [CNT_W-1:0] cnt;
    logic [FET_N-1:0] gate_en;
    logic start_req;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_s;

  state_s r;
  state_s n;

  logic [RAW_W-1:0] raw_in;
  assign raw_in = {pwm_on, bootstrap_uv, short_fault, watchdog_in, loss_of_sync, over_temp,
                   watchdog_fault, logic_regulator_uv, gate_drive_supply_uv,
                   motor_supply_por, motor_supply_uv};

  // Combinational handshake and status outputs
  assign awready = !r.aw_held && !r.bvalid;
  assign wready = !r.w_held && !r.bvalid;
  assign arready = !r.rvalid;
  assign bvalid = r.bvalid;
  assign bresp = r.bresp;
  assign rvalid = r.rvalid;
  assign rdata = r.rdata;
  assign rresp = r.rresp;
  assign gate_enable = r.gate_en;
  assign mcu_reset_out_n = (r.mr != MR_HOLD);
  assign start_request = r.start_req;
  assign irq = |(r.irq_stat & r.irq_en);

  always_comb begin
    logic [DIAG_W-1:0] ev;
    logic [DIAG_W-1:0] diag_clr;
    logic [DIAG_W-1:0] act;
    logic [FET_N-1:0] sf;
    logic [FET_N-1:0] bu;
    logic [PHASE_N-1:0] pwm;
    logic [PHASE_N-1:0] pwm_prev;
    logic [31:0] bmask;
    logic [DEMAND_W-1:0] demand;
    logic stop_en;
    logic restart_en;
    logic inhibit;
    logic uv;
    logic ot;
    logic los;
    logic lruv;
    logic wdf;
    logic wd_edge;
    logic critical;
    logic demand_rel;
    logic run_rel;
    logic release_ev;
    logic mr_src;
    logic global_off;
    ev = '0;
    diag_clr = '0;
    act = '0;
    sf = '0;
    bu = '0;
    pwm = '0;
    pwm_prev = '0;
    bmask = '0;
    demand = '0;
    n = r;
    n.start_req = 1'b0;
    n.read_release = 1'b0;

    // Two-stage synchroniser; sync2 and its delayed copy prev feed logic
    n.sync1 = raw_in;
    n.sync2 = r.sync1;
    n.prev = r.sync2;

    stop_en = r.ctrl[CTRL_STOP_ON_FAULT_BIT];
    restart_en = r.ctrl[CTRL_AUTO_RESTART_BIT];
    inhibit = r.ctrl[CTRL_INHIBIT_BIT];
    demand = r.ctrl[CTRL_DEMAND_LSB +: DEMAND_W];

    // Masked diagnostics generate nothing at all; the POR and gate supply undervoltage bits ignore the mask
    act = ~(r.mask & ~UNMASKABLE);
    sf = r.sync2[8 +: FET_N] & {FET_N{act[DG_SHORT]}};
    bu = r.sync2[8 + FET_N +: FET_N] & {FET_N{act[DG_BOOT_UV]}};
    pwm = r.sync2[8 + 2 * FET_N +: PHASE_N];
    pwm_prev = r.prev[8 + 2 * FET_N +: PHASE_N];
    uv = r.sync2[0] & act[DG_SUPPLY_UV];
    critical = r.sync2[1] | r.sync2[2];
    lruv = r.sync2[3] & act[DG_LOGIC_UV];
    wdf = r.sync2[4] & act[DG_WD_FAULT];
    ot = r.sync2[5] & act[DG_OVER_TEMP];
    los = r.sync2[6] & act[DG_LOSS_SYNC];
    wd_edge = r.sync2[7] ^ r.prev[7];

    ev[DG_SUPPLY_UV] = uv;
    ev[DG_GATE_SUPPLY_UV] = r.sync2[2];
    ev[DG_POR] = r.sync2[1];
    ev[DG_SHORT] = |sf;
    ev[DG_BOOT_UV] = |bu;
    ev[DG_OVER_TEMP] = ot;
    ev[DG_LOSS_SYNC] = los;
    ev[DG_LOGIC_UV] = lruv;
    ev[DG_WD_FAULT] = wdf;
    n.ev_prev = ev;

    // Release sequences from the host
    demand_rel = r.demand_zero_seen && (demand != '0);
    if (demand == '0) begin
      n.demand_zero_seen = 1'b1;
    end else if (demand_rel) begin
      n.demand_zero_seen = 1'b0;
    end
    run_rel = r.run_low_seen && r.ctrl[CTRL_RUN_BIT];
    if (!r.ctrl[CTRL_RUN_BIT]) begin
      n.run_low_seen = 1'b1;
    end else if (run_rel) begin
      n.run_low_seen = 1'b0;
    end
    // A motor supply POR (raw bit 1) also acts as a release
    release_ev = demand_rel || run_rel || r.read_release || r.sync2[1];

    // Supply undervoltage latch, only when not restarting automatically
    if (stop_en && !restart_en && uv) begin
      n.uv_lat = 1'b1;
    end else if (release_ev || restart_en || !stop_en) begin
      n.uv_lat = 1'b0;
    end
    if (stop_en && restart_en && !uv && !r.uv_lat && r.ev_prev[DG_SUPPLY_UV]) begin
      n.start_req = 1'b1;
    end

    // Whole-bridge latch for short and bootstrap faults
    if (stop_en && (|sf || |bu)) begin
      n.bridge_lat = 1'b1;
    end else if (release_ev || !stop_en) begin
      n.bridge_lat = 1'b0;
    end

    // Per-transistor latch; set wins over a coincident PWM-on release
    for (int i = 0; i < FET_N; i++) begin
      if (!stop_en && (sf[i] || bu[i])) begin
        n.fet_lat[i] = 1'b1;
      end else if (stop_en || (pwm[i / 2] && !pwm_prev[i / 2])) begin
        n.fet_lat[i] = 1'b0;
      end
    end

    // Loss of synchronisation
    if (los && !restart_en) begin
      n.los_lat = 1'b1;
    end else if (release_ev || restart_en) begin
      n.los_lat = 1'b0;
    end
    if (los && !r.ev_prev[DG_LOSS_SYNC] && restart_en) begin
      n.start_req = 1'b1;
    end

    // MCU reset sequencing for logic supply, watchdog and thermal faults
    mr_src = stop_en && (lruv || wdf || ot);
    case (r.mr)
      MR_IDLE: begin
        if (mr_src) begin
          n.mr = MR_HOLD;
          n.cnt = '0;
        end
      end
      MR_HOLD: begin
        // Reset low stays asserted 10 ms after the last source goes away
        if (mr_src) begin
          n.cnt = '0;
        end else if (r.cnt == CNT_W'(OT_HOLD_CYC - 1)) begin
          n.mr = MR_WAIT;
          n.cnt = '0;
        end else begin
          n.cnt = r.cnt + 1'b1;
        end
      end
      MR_WAIT: begin
        if (mr_src) begin
          n.mr = MR_HOLD;
          n.cnt = '0;
        end else if (r.cnt == CNT_W'(WD_ARM_CYC - 1)) begin
          n.mr = MR_ARM;
          n.cnt = '0;
        end else begin
          n.cnt = r.cnt + 1'b1;
        end
      end
      MR_ARM: begin
        if (mr_src) begin
          n.mr = MR_HOLD;
          n.cnt = '0;
        end else if (wd_edge) begin
          n.mr = MR_IDLE;
        end
      end
      default: begin
        n.mr = MR_IDLE;
        n.cnt = '0;
      end
    endcase

    // Global disable requests meet in one OR; per-transistor latches and faults then gate each bit
    global_off = critical
      || (stop_en && uv) || r.uv_lat
      || (stop_en && (|sf || |bu)) || r.bridge_lat
      || (stop_en && ot)
      || los || r.los_lat
      || (r.mr != MR_IDLE);
    n.gate_en = {FET_N{!global_off}} & ~r.fet_lat & ~(stop_en ? '0 : (sf | bu));

    // AXI write channel: address and data may arrive in either order
    if (awvalid && awready) begin
      n.aw_held = 1'b1;
      n.aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      n.w_held = 1'b1;
      n.w_data = wdata;
      n.w_strb = wstrb;
    end
    for (int b = 0; b < 4; b++) begin
      bmask[8 * b +: 8] = {8{r.w_strb[b]}};
    end
    if (r.aw_held && r.w_held && !r.bvalid) begin
      n.aw_held = 1'b0;
      n.w_held = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = RESP_OKAY;
      case (r.aw_addr)
        CTRL_OFS: n.ctrl = (r.ctrl & ~(bmask & CTRL_WMASK)) | (r.w_data & bmask & CTRL_WMASK);
        MASK_OFS: n.mask = (r.mask & ~bmask[DIAG_W-1:0]) | (r.w_data[DIAG_W-1:0] & bmask[DIAG_W-1:0]);
        IRQ_CLR_OFS: n.irq_stat = r.irq_stat & ~(r.w_data[DIAG_W-1:0] & bmask[DIAG_W-1:0]);
        IRQ_EN_OFS: n.irq_en = (r.irq_en & ~bmask[DIAG_W-1:0]) | (r.w_data[DIAG_W-1:0] & bmask[DIAG_W-1:0]);
        DIAG_OFS, STATE_OFS, IRQ_STAT_OFS: n.bresp = RESP_OKAY;
        default: n.bresp = RESP_SLVERR;
      endcase
    end
    if (r.bvalid && bready) begin
      n.bvalid = 1'b0;
    end

    // AXI read channel
    if (arvalid && arready) begin
      n.rvalid = 1'b1;
      n.rresp = RESP_OKAY;
      n.rdata = '0;
      case (araddr)
        CTRL_OFS: n.rdata = r.ctrl;
        MASK_OFS: n.rdata[DIAG_W-1:0] = r.mask;
        DIAG_OFS: begin
          n.rdata[DIAG_W-1:0] = r.diag;
          if (!inhibit) begin
            diag_clr = r.diag;
            n.read_release = 1'b1;
          end
        end
        STATE_OFS: n.rdata = {8'h00, r.mr, 1'b0, r.uv_lat, r.bridge_lat, r.los_lat,
                              2'b00, r.fet_lat, 2'b00, r.gate_en};
        IRQ_STAT_OFS: n.rdata[DIAG_W-1:0] = r.irq_stat;
        IRQ_CLR_OFS: n.rdata = '0;
        IRQ_EN_OFS: n.rdata[DIAG_W-1:0] = r.irq_en;
        default: n.rresp = RESP_SLVERR;
      endcase
    end
    if (r.rvalid && rready) begin
      n.rvalid = 1'b0;
    end

    // Sticky diagnostics: a fault present in the clearing cycle sets again
    n.diag = (r.diag & ~diag_clr) | ev;
    if (arvalid && arready && araddr == IRQ_STAT_OFS) begin
      n.irq_stat = n.irq_stat;
    end
    n.irq_stat = n.irq_stat | (ev & ~r.ev_prev);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
      r.ctrl <= CTRL_RESET;
      r.mask <= MASK_RESET;
      r.mr <= MR_IDLE;
    end else begin
      r <= n;
    end
  end

endmodule : motor_fault_response_controller

`default_nettype wire

// file: test/motor_fault_response_controller_props.sv
// Purpose: Port-level checks on the fault response controller.
// Assumes: One clock domain, synchronous active-low reset.
// Notes: Masked diagnostics cannot be seen here, so only unmaskable faults are checked.
`timescale 1ns/1ps
`default_nettype none
module fault_resp_props
  import fault_resp_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic motor_supply_por,
  input wire logic gate_drive_supply_uv,
  input wire logic [FET_N-1:0] gate_enable,
  input wire logic mcu_reset_out_n,
  input wire logic start_request,
  input wire logic awready,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  property p_por_off;
    motor_supply_por |-> ##3 gate_enable == '0;
  endproperty
  a_por_off: assert property (p_por_off) else $error("gates on during supply POR");
  property p_gate_supply_off;
    gate_drive_supply_uv |-> ##3 gate_enable == '0;
  endproperty
  a_gate_supply_off: assert property (p_gate_supply_off) else $error("gates on in gate supply uv");
  property p_mcu_off;
    !mcu_reset_out_n ##1 !mcu_reset_out_n |-> gate_enable == '0;
  endproperty
  a_mcu_off: assert property (p_mcu_off) else $error("gates on during MCU reset");
  property p_pulse;
    start_request |=> !start_request;
  endproperty
  a_pulse: assert property (p_pulse) else $error("start request longer than one cycle");
  property p_b_hold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
  property p_r_hold;
    rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
  property p_ar_block;
    rvalid |-> !arready;
  endproperty
  a_ar_block: assert property (p_ar_block) else $error("read address taken while busy");
  property p_aw_block;
    bvalid |-> !awready && !wready;
  endproperty
  a_aw_block: assert property (p_aw_block) else $error("write taken while busy");
  c_start: cover property (start_request);
  c_mcu: cover property (!mcu_reset_out_n);
  c_read: cover property (rvalid && rready);
endmodule : fault_resp_props
`default_nettype wire

// file: test/fault_pin_model.sv
// Purpose: Fault detectors, PWM phases and MCU watchdog toggle facing the controller.
// Assumes: Levels change just after a rising edge.
// Notes: Pins are not synchronised here; the controller does that.
`timescale 1ns/1ps
`default_nettype none
module fault_pin_model
  import fault_resp_pkg::*;
(
  input wire logic aclk,
  output logic [DIAG_W-1:0] f,
  output logic [FET_N-1:0] sh,
  output logic [FET_N-1:0] bt,
  output logic [PHASE_N-1:0] pw,
  output logic wd
);
  initial begin
    f = '0;
    sh = '0;
    bt = '0;
    pw = '0;
    wd = 1'b0;
  end
  task automatic set(input logic [DIAG_W-1:0] nf, input logic [FET_N-1:0] ns, input logic [FET_N-1:0] nb);
    @(posedge aclk);
    f <= nf;
    sh <= ns;
    bt <= nb;
  endtask : set
  task automatic pwm(input logic [PHASE_N-1:0] p);
    @(posedge aclk);
    pw <= p;
  endtask : pwm
  // Any edge counts, so a toggle is one watchdog event
  task automatic kick();
    @(posedge aclk);
    wd <= ~wd;
  endtask : kick
endmodule : fault_pin_model
`default_nettype wire

// file: test/test_motor_fault_response_controller.sv
// Purpose: Self-checking bench for the fault response controller.
// Assumes: Short hold counts for the MCU reset sequence.
// Notes: Bus handshakes are judged at the falling edge, driven after the rising edge.
`timescale 1ns/1ps
`default_nettype none
module test_motor_fault_response_controller;
  import fault_resp_pkg::*;
  localparam int OTC = 20;
  localparam int WDC = 50;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic [2:0] prot = 3'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, mcu_reset_out_n, start_request, irq;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, q;
  logic [FET_N-1:0] gate_enable;
  logic [FET_N-1:0] sh, bt;
  logic [PHASE_N-1:0] pw;
  logic [DIAG_W-1:0] f;
  logic wd;
  int n_errors = 0, cmp_count = 0, n_srq = 0;
  always #5 aclk = ~aclk;
  always @(negedge aclk) if (start_request === 1'b1) n_srq <= n_srq + 1;
  fault_pin_model fm(.aclk, .f, .sh, .bt, .pw, .wd);
  motor_fault_response_controller #(.OT_HOLD_CYC(OTC), .WD_ARM_CYC(WDC)) DUT(
    .aclk, .aresetn, .awaddr, .awprot(prot), .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot(prot), .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .motor_supply_uv(f[DG_SUPPLY_UV]),
    .motor_supply_por(f[DG_POR]), .gate_drive_supply_uv(f[DG_GATE_SUPPLY_UV]),
    .logic_regulator_uv(f[DG_LOGIC_UV]), .watchdog_fault(f[DG_WD_FAULT]), .watchdog_in(wd),
    .over_temp(f[DG_OVER_TEMP]), .loss_of_sync(f[DG_LOSS_SYNC]), .short_fault(sh),
    .bootstrap_uv(bt), .pwm_on(pw), .gate_enable, .mcu_reset_out_n, .start_request, .irq);
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, da, dw;
    da = 1'b0;
    dw = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(da && dw)) begin
      @(negedge aclk);
      ta = awready && !da;
      tw = wready && !dw;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      da = da || ta;
      dw = dw || tw;
    end
    do @(negedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    @(posedge aclk);
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge aclk); while (arready !== 1'b1);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (rvalid !== 1'b1);
    q = rdata;
    r = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask : rd
  task automatic gw(input logic [FET_N-1:0] e);
    for (int i = 0; i < 40 && gate_enable !== e; i++) @(negedge aclk);
    chk("gate_enable", 32'(e), 32'(gate_enable));
  endtask : gw
  task automatic up(input logic [DIAG_W-1:0] v);
    fm.set(v, '0, '0);
    repeat (10) @(posedge aclk);
    fm.set('0, '0, '0);
    repeat (30) @(posedge aclk);
  endtask : up
  task automatic t_reset();
    rd(CTRL_OFS);
    chk("ctrl", CTRL_RESET, q);
    rd(MASK_OFS);
    chk("mask", 32'(MASK_RESET), q);
    rd(8'h40);
    chk("rresp", 32'(RESP_SLVERR), 32'(r));
    wr(CTRL_OFS, 32'h0000_0107);
    chk("bresp", 32'(RESP_OKAY), 32'(r));
    rd(CTRL_OFS);
    chk("ctrl", 32'h0000_0107, q);
    prot <= 3'h7;
    wstrb <= 4'h2;
    wr(CTRL_OFS, 32'h0000_0000);
    rd(CTRL_OFS);
    chk("ctrl_strobe", 32'h0000_0007, q);
    wstrb <= 4'hF;
    wr(CTRL_OFS, 32'h0000_0107);
    wr(8'h40, 32'h0000_0000);
    chk("bresp", 32'(RESP_SLVERR), 32'(r));
    prot <= 3'h0;
    rd(IRQ_CLR_OFS);
    chk("irq_clear", 32'h0, q);
    gw(6'h3F);
  endtask : t_reset
  task automatic t_uv_auto();
    int s0;
    s0 = n_srq;
    fm.set(9'h001, '0, '0);
    gw(6'h00);
    fm.set('0, '0, '0);
    gw(6'h3F);
    repeat (2) @(posedge aclk);
    chk("start_pulses", 32'(s0 + 1), 32'(n_srq));
    rd(DIAG_OFS);
    chk("diag", 32'h1, q);
    rd(DIAG_OFS);
    chk("diag", 32'h0, q);
  endtask : t_uv_auto
  task automatic t_uv_latch();
    wr(CTRL_OFS, 32'h0000_0105);
    up(9'h001);
    gw(6'h00);
    wr(CTRL_OFS, 32'h0000_0101);
    wr(CTRL_OFS, 32'h0000_0105);
    gw(6'h3F);
    up(9'h001);
    wr(CTRL_OFS, 32'h0000_0005);
    gw(6'h00);
    wr(CTRL_OFS, 32'h0000_0505);
    gw(6'h3F);
    wr(CTRL_OFS, 32'h0000_050D);
    up(9'h001);
    rd(DIAG_OFS);
    repeat (20) @(posedge aclk);
    gw(6'h00);
    wr(CTRL_OFS, 32'h0000_0505);
    rd(DIAG_OFS);
    gw(6'h3F);
  endtask : t_uv_latch
  task automatic t_fet();
    wr(CTRL_OFS, 32'h0000_0506);
    wr(IRQ_EN_OFS, 32'h0000_0008);
    fm.set('0, 6'h04, '0);
    gw(6'h3B);
    chk("irq", 32'h1, 32'(irq));
    fm.set('0, '0, '0);
    repeat (10) @(posedge aclk);
    gw(6'h3B);
    fm.pwm(3'h2);
    gw(6'h3F);
    wr(IRQ_CLR_OFS, 32'h0000_0008);
    @(negedge aclk);
    chk("irq", 32'h0, 32'(irq));
    fm.set('0, '0, 6'h20);
    gw(6'h1F);
    chk("irq", 32'h0, 32'(irq));
    fm.set('0, '0, '0);
    fm.pwm(3'h6);
    gw(6'h3F);
  endtask : t_fet
  task automatic t_esf();
    wr(CTRL_OFS, 32'h0000_0507);
    fm.set('0, '0, 6'h01);
    gw(6'h00);
    fm.set('0, '0, '0);
    fm.pwm(3'h7);
    repeat (30) @(posedge aclk);
    gw(6'h00);
    wr(CTRL_OFS, 32'h0000_0503);
    wr(CTRL_OFS, 32'h0000_0507);
    gw(6'h3F);
    wr(CTRL_OFS, 32'h0000_0506);
    fm.set(9'h020, '0, '0);
    repeat (30) @(posedge aclk);
    gw(6'h3F);
    fm.set('0, '0, '0);
  endtask : t_esf
  task automatic t_los();
    int s0;
    wr(CTRL_OFS, 32'h0000_0507);
    s0 = n_srq;
    fm.set(9'h040, '0, '0);
    gw(6'h00);
    repeat (2) @(posedge aclk);
    chk("start_pulses", 32'(s0 + 1), 32'(n_srq));
    fm.set('0, '0, '0);
    gw(6'h3F);
    wr(CTRL_OFS, 32'h0000_0505);
    up(9'h040);
    gw(6'h00);
    rd(DIAG_OFS);
    gw(6'h3F);
  endtask : t_los
  task automatic t_mcu();
    int c;
    wr(CTRL_OFS, 32'h0000_0507);
    for (int k = 0; k < 3; k++) begin
      fm.set(9'h001 << (k == 0 ? DG_OVER_TEMP : k == 1 ? DG_LOGIC_UV : DG_WD_FAULT), '0, '0);
      for (c = 0; c < 20 && mcu_reset_out_n !== 1'b0; c++) @(negedge aclk);
      chk("mcu_reset_out_n", 32'h0, 32'(mcu_reset_out_n));
      fm.set('0, '0, '0);
      for (c = 0; c < 100 && mcu_reset_out_n !== 1'b1; c++) @(negedge aclk);
      chk("reset_hold", 32'h1, 32'(c >= OTC && c <= OTC + 8));
      fm.kick();
      repeat (10) @(posedge aclk);
      gw(6'h00);
      repeat (WDC) @(posedge aclk);
      fm.kick();
      gw(6'h3F);
    end
    rd(DIAG_OFS);
  endtask : t_mcu
  task automatic t_crit();
    wr(MASK_OFS, 32'h0000_0001);
    up(9'h001);
    gw(6'h3F);
    rd(DIAG_OFS);
    chk("diag", 32'h0, q);
    wr(MASK_OFS, 32'h0000_01FF);
    fm.set(9'h002, '0, '0);
    gw(6'h00);
    fm.set('0, '0, '0);
    gw(6'h3F);
    fm.set(9'h004, '0, '0);
    gw(6'h00);
    fm.set('0, '0, '0);
  endtask : t_crit
  task automatic results();
    $display("checks %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_uv_auto();
    t_uv_latch();
    t_fet();
    t_esf();
    t_los();
    t_mcu();
    t_crit();
    results();
  end
  initial begin
    #300000;
    n_errors++;
    results();
  end
endmodule : test_motor_fault_response_controller
bind motor_fault_response_controller fault_resp_props u_props(.aclk, .aresetn,
  .motor_supply_por, .gate_drive_supply_uv, .gate_enable, .mcu_reset_out_n, .start_request,
  .awready, .wready, .bvalid, .bready, .bresp, .arready, .rvalid, .rready, .rdata);
`default_nettype wire
